// ===== core/ddr3_wl_defs.svh
// Constants for the memory-side leveling and initialization tracker
`ifndef DDR3_WL_DEFS_SVH
`define DDR3_WL_DEFS_SVH

// ==========================================================
// Register map (byte addresses on the plain register port)
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_DLLCNT 8'h08
// Control field: feedback delay in core cycles
`define CTRL_WLO_LSB 0
`define CTRL_WLO_MSB 3
// Status bit positions
`define ST_LEVEL_BIT 0
`define ST_QOFF_BIT 1
`define ST_DLLOK_BIT 2
`define ST_DQDRV_BIT 3
`define ST_PRIME_LSB 4

// ==========================================================
// Mode register command fields
`define BA_MR0 3'h0
`define BA_MR1 3'h1
`define MR1_LEVEL_BIT 7
`define MR1_QOFF_BIT 12
`define MR0_DLLRST_BIT 8

// ==========================================================
// Timing: lock time and mode-set delay counted in memory clocks
`define DLLK_CK 10'd512
`define TMOD_CK 4'd12
// Feedback delay as a time, and the core period it is counted in
`define WLO_NS 9
`define CORE_NS 10
`define WLO_CYC ((`WLO_NS + `CORE_NS - 1) / `CORE_NS)

`endif

// ===== core/ddr3_wl_pkg.sv
// Types shared by the leveling tracker modules
package ddr3_wl_pkg;
    // Leveling mode of the rank
    typedef enum logic [1:0] {
        ST_NORMAL,
        ST_LEVEL,
        ST_EXIT
    } wl_state_e;
endpackage

// ===== core/pin_sync_if.sv
// Synchronised pin levels and edges passed from the pin stage to the core
`timescale 1ns/10ps
`default_nettype none
interface pin_sync_if #(parameter int LANES = 2);
    logic ck_lvl;              // Memory clock level, synchronised
    logic ck_rise;             // One-cycle pulse on memory clock rise
    logic [LANES-1:0] dqs_rise; // One-cycle pulse per strobe rise
    logic mem_rst_n;           // Memory reset pin, synchronised
    logic cke;                 // Clock enable pin, synchronised
    logic cmd_mrs;             // Mode-set command decode level
    logic [2:0] ba;            // Bank address pins
    logic [12:0] addr;         // Address pins
    modport sync (output ck_lvl, ck_rise, dqs_rise, mem_rst_n, cke, cmd_mrs, ba, addr);
    modport core (input ck_lvl, ck_rise, dqs_rise, mem_rst_n, cke, cmd_mrs, ba, addr);
endinterface
`default_nettype wire

// ===== core/pin_sync.sv
// Two-stage synchronisers for all memory pins, edge finders for the clock and strobes
`timescale 1ns/10ps
`default_nettype none
module pin_sync
    import ddr3_wl_pkg::*;
#(
    parameter int LANES = 2
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Raw pins
    input wire logic ck,
    input wire logic [LANES-1:0] dqs,
    input wire logic reset_n,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic [12:0] addr,
    // Synchronised side
    pin_sync_if.sync sif
);
    // Strobes, clock, reset, enable, four command pins, bank and address
    localparam int W = LANES + 23;

    // ==========================================================
    // Synchroniser chain per pin bit
    logic [W-1:0] raw;   // Packed pin bundle
    logic [W-1:0] s1_r;  // First stage, read only by s2_r
    logic [W-1:0] s2_r;  // Stable synchronised level
    logic [W-1:0] s3_r;  // Delayed copy for edge finding
    logic [W-1:0] s1_nxt;
    logic [W-1:0] s2_nxt;
    logic [W-1:0] s3_nxt;

    assign raw = {dqs, ck, reset_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr};

    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            // Next values: plain shift
            always_comb begin
                s1_nxt[gi] = raw[gi];
                s2_nxt[gi] = s1_r[gi];
                s3_nxt[gi] = s2_r[gi];
            end
            // Registers only
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    s1_r[gi] <= 1'b0;
                    s2_r[gi] <= 1'b0;
                    s3_r[gi] <= 1'b0;
                end else begin
                    s1_r[gi] <= s1_nxt[gi];
                    s2_r[gi] <= s2_nxt[gi];
                    s3_r[gi] <= s3_nxt[gi];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Edges and decode only from the second stage onward
    assign sif.addr = s2_r[12:0];
    assign sif.ba = s2_r[15:13];
    // Mode-set: select, row, column and write strobes all low
    assign sif.cmd_mrs = (s2_r[19:16] == 4'h0);
    assign sif.cke = s2_r[20];
    assign sif.mem_rst_n = s2_r[21];
    assign sif.ck_lvl = s2_r[22];
    assign sif.ck_rise = s2_r[22] & ~s3_r[22];
    assign sif.dqs_rise = s2_r[W-1:23] & ~s3_r[W-1:23];
endmodule
`default_nettype wire

// ===== core/ddr3_wl_core.sv
// Memory-side write leveling feedback, mode tracking and DLL lock timing
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ddr3_wl_defs.svh"
module ddr3_wl_core
    import ddr3_wl_pkg::*;
#(
    parameter int DQ_W = 16
) (
    // Core clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Memory pins from the controller
    input wire logic ck,
    input wire logic [DQ_W/8-1:0] dqs,
    input wire logic reset_n,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic [12:0] addr,
    // Data pins toward the controller
    output logic [DQ_W-1:0] dq_out,
    output logic [DQ_W-1:0] dq_oe,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);
    localparam int LANES = DQ_W / 8;

    // ==========================================================
    // Pin synchronisation
    pin_sync_if #(.LANES(LANES)) sif ();

    pin_sync #(.LANES(LANES)) u_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .ck(ck),
        .dqs(dqs),
        .reset_n(reset_n),
        .cke(cke),
        .cs_n(cs_n),
        .ras_n(ras_n),
        .cas_n(cas_n),
        .we_n(we_n),
        .ba(ba),
        .addr(addr),
        .sif(sif)
    );

    // ==========================================================
    // Mode tracking, DLL lock and exit timing
    wl_state_e state_r, state_nxt;   // Leveling mode
    logic qoff_r, qoff_nxt;          // Outputs disabled in this rank
    logic [9:0] dll_cnt_r, dll_cnt_nxt; // Clocks since DLL reset
    logic dll_ok_r, dll_ok_nxt;      // DLL locked
    logic [3:0] tmod_r, tmod_nxt;    // Clocks since leveling-off command
    logic mrs_ev;                    // Mode-set taken on a clock rise

    // Commands count only on a rising memory clock with enable high
    assign mrs_ev = sif.ck_rise & sif.cke & sif.cmd_mrs;

    // Next-state for mode tracking
    always_comb begin
        state_nxt = state_r;
        qoff_nxt = qoff_r;
        dll_cnt_nxt = dll_cnt_r;
        dll_ok_nxt = dll_ok_r;
        tmod_nxt = tmod_r;
        if (!sif.mem_rst_n) begin
            // Memory reset clears all tracked modes
            state_nxt = ST_NORMAL;
            qoff_nxt = 1'b0;
            dll_cnt_nxt = 10'h000;
            dll_ok_nxt = 1'b0;
            tmod_nxt = 4'h0;
        end else begin
            // Lock count advances on memory clock rises only
            if (sif.ck_rise && !dll_ok_r && dll_cnt_r != 10'h000) begin
                dll_cnt_nxt = dll_cnt_r + 10'h001;
                if (dll_cnt_r == `DLLK_CK - 10'h001) begin
                    dll_ok_nxt = 1'b1;
                end
            end
            // Exit hold ends a mode-set delay after the exit command
            if (state_r == ST_EXIT && sif.ck_rise) begin
                tmod_nxt = tmod_r + 4'h1;
                if (tmod_r == `TMOD_CK - 4'h1) begin
                    state_nxt = ST_NORMAL;
                end
            end
            if (mrs_ev && sif.ba == `BA_MR1) begin
                // Leveling bit and output-off bit of mode register one
                qoff_nxt = sif.addr[`MR1_QOFF_BIT];
                if (sif.addr[`MR1_LEVEL_BIT]) begin
                    state_nxt = ST_LEVEL;
                end else if (state_r == ST_LEVEL) begin
                    state_nxt = ST_EXIT;
                    tmod_nxt = 4'h0;
                end
            end
            if (mrs_ev && sif.ba == `BA_MR0 && sif.addr[`MR0_DLLRST_BIT]) begin
                // A DLL reset restarts the lock time from one
                dll_cnt_nxt = 10'h001;
                dll_ok_nxt = 1'b0;
            end
        end
    end

    // Registers for mode tracking
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_NORMAL;
            qoff_r <= 1'b0;
            dll_cnt_r <= 10'h000;
            dll_ok_r <= 1'b0;
            tmod_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            qoff_r <= qoff_nxt;
            dll_cnt_r <= dll_cnt_nxt;
            dll_ok_r <= dll_ok_nxt;
            tmod_r <= tmod_nxt;
        end
    end

    // ==========================================================
    // Data pin drive
    logic drv;       // Data pins driven in this rank
    logic fb_on;     // Strobe feedback accepted
    logic [3:0] wlo_r, wlo_nxt; // Feedback delay in core cycles

    // Driving spans leveling and its exit hold; undefined data shows as low
    assign drv = (state_r != ST_NORMAL) & ~qoff_r;
    assign fb_on = (state_r == ST_LEVEL) & ~qoff_r;

    logic [LANES-1:0] pend_r, pend_nxt;   // Clock level caught per lane
    logic [LANES-1:0] prime_r, prime_nxt; // Level shown on prime pin
    logic [LANES-1:0][3:0] cnt_r, cnt_nxt; // Delay countdown per lane
    logic [DQ_W-1:0] oe_r, oe_nxt;        // Output enables

    genvar gl;
    generate
        for (gl = 0; gl < LANES; gl++) begin : g_lane
            // Strobe is only an input: its rise samples the clock level
            always_comb begin
                pend_nxt[gl] = pend_r[gl];
                prime_nxt[gl] = prime_r[gl];
                cnt_nxt[gl] = cnt_r[gl];
                if (!fb_on) begin
                    cnt_nxt[gl] = 4'h0;
                    prime_nxt[gl] = drv & prime_r[gl];
                end else if (sif.dqs_rise[gl]) begin
                    pend_nxt[gl] = sif.ck_lvl;
                    // A zero delay setting still takes one cycle
                    cnt_nxt[gl] = (wlo_r == 4'h0) ? 4'h1 : wlo_r;
                end else if (cnt_r[gl] == 4'h1) begin
                    prime_nxt[gl] = pend_r[gl];
                    cnt_nxt[gl] = 4'h0;
                end else if (cnt_r[gl] != 4'h0) begin
                    cnt_nxt[gl] = cnt_r[gl] - 4'h1;
                end
            end
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    pend_r[gl] <= 1'b0;
                    prime_r[gl] <= 1'b0;
                    cnt_r[gl] <= 4'h0;
                end else begin
                    pend_r[gl] <= pend_nxt[gl];
                    prime_r[gl] <= prime_nxt[gl];
                    cnt_r[gl] <= cnt_nxt[gl];
                end
            end
            // Prime pin per lane at bit zero of the byte; others stay low
            assign dq_out[gl*8] = prime_r[gl];
            assign dq_out[gl*8+7:gl*8+1] = 7'h00;
        end
    endgenerate

    // Enables: all pins together, from a flop
    always_comb begin
        oe_nxt = {DQ_W{(state_nxt != ST_NORMAL) & ~qoff_nxt}};
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            oe_r <= '0;
        end else begin
            oe_r <= oe_nxt;
        end
    end
    assign dq_oe = oe_r;

    // ==========================================================
    // Register port
    logic [31:0] rdata_r, rdata_nxt; // Read data, valid one cycle after strobe

    // Decode writes and reads
    always_comb begin
        wlo_nxt = wlo_r;
        rdata_nxt = 32'h0000_0000;
        if (reg_wr && reg_addr == `OFF_CTRL) begin
            wlo_nxt = reg_wdata[`CTRL_WLO_MSB:`CTRL_WLO_LSB];
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `OFF_CTRL: rdata_nxt[`CTRL_WLO_MSB:`CTRL_WLO_LSB] = wlo_r;
                `OFF_STATUS: begin
                    rdata_nxt[`ST_LEVEL_BIT] = (state_r == ST_LEVEL);
                    rdata_nxt[`ST_QOFF_BIT] = qoff_r;
                    rdata_nxt[`ST_DLLOK_BIT] = dll_ok_r;
                    rdata_nxt[`ST_DQDRV_BIT] = oe_r[0];
                    rdata_nxt[`ST_PRIME_LSB +: LANES] = prime_r;
                end
                `OFF_DLLCNT: rdata_nxt[9:0] = dll_cnt_r;
                // Unmapped addresses read as zero
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wlo_r <= 4'(`WLO_CYC);
            rdata_r <= 32'h0000_0000;
        end else begin
            wlo_r <= wlo_nxt;
            rdata_r <= rdata_nxt;
        end
    end
    assign reg_rdata = rdata_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    property p_prime_sample;
        (sif.dqs_rise[0] && fb_on && wlo_r <= 4'h1 && sif.ck_lvl ##1
            !sif.dqs_rise[0] && fb_on) |=> dq_out[0];
    endproperty
    a_prime_sample: assert property (p_prime_sample) else $error("prime pin missed sample");

    property p_nonprime_low;
        dq_oe[0] |-> dq_out[7:1] == 7'h00;
    endproperty
    a_nonprime_low: assert property (p_nonprime_low) else $error("non-prime pin not low");

    property p_lanes_match;
        dq_oe[DQ_W-1] == dq_oe[0] && dq_out[DQ_W-1:DQ_W-7] == 7'h00;
    endproperty
    a_lanes_match: assert property (p_lanes_match) else $error("upper lane mismatch");

    property p_exit_hold;
        $rose(state_r == ST_EXIT) && !qoff_r |=> dq_oe[0] [*8];
    endproperty
    a_exit_hold: assert property (p_exit_hold) else $error("data released early on exit");

    property p_exit_bound;
        state_r == ST_EXIT |-> tmod_r < `TMOD_CK;
    endproperty
    a_exit_bound: assert property (p_exit_bound) else $error("exit hold overran");

    property p_dll_time;
        sif.mem_rst_n && sif.ck_rise && dll_cnt_r == `DLLK_CK - 10'h001 && !mrs_ev |=> dll_ok_r;
    endproperty
    a_dll_time: assert property (p_dll_time) else $error("DLL lock late");

    property p_dll_early;
        dll_ok_r && !$past(dll_ok_r) |-> $past(dll_cnt_r) == `DLLK_CK - 10'h001;
    endproperty
    a_dll_early: assert property (p_dll_early) else $error("DLL lock early");

    property p_enter_drive;
        mrs_ev && sif.mem_rst_n && sif.ba == `BA_MR1 && sif.addr[`MR1_LEVEL_BIT]
            && !sif.addr[`MR1_QOFF_BIT] |=> ##1 dq_oe[0];
    endproperty
    a_enter_drive: assert property (p_enter_drive) else $error("no drive on leveling entry");

    c_enter: cover property (state_r == ST_NORMAL ##1 state_r == ST_LEVEL);
    c_prime_high: cover property (fb_on && $rose(prime_r[0]));
    c_exit_done: cover property (state_r == ST_EXIT ##1 state_r == ST_NORMAL);
    c_dll_lock: cover property ($rose(dll_ok_r));
endmodule
`default_nettype wire

// ===== sim/ddr3_ctrl_model.sv
// Pin-level memory controller model driving clock, strobes and commands
`timescale 1ns/10ps
`default_nettype none
module ddr3_ctrl_model (
    // Memory clock and strobes
    output logic ck,
    output logic [1:0] dqs,
    // Reset and clock enable
    output logic reset_n,
    output logic cke,
    // Command and address
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [2:0] ba,
    output logic [12:0] addr
);
    // ==========================================================
    // Clock and idle pins
    // Free-running memory clock, phase unrelated to the core clock
    initial begin
        ck = 1'b0;
        #3.7;
        forever #62.5 ck = ~ck;
    end
    // Idle pins: reset held, clock enable low, no command
    initial begin
        dqs = 2'h0;
        reset_n = 1'b0;
        cke = 1'b0;
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        ba = 3'h0;
        addr = 13'h0;
    end
    // ==========================================================
    // Tasks
    // Reset and clock enable levels; hold times shortened, the device does not time them
    task automatic set_pins(input logic rst, input logic ce);
        @(negedge ck);
        reset_n = rst;
        repeat (6) @(negedge ck);
        cke = ce;
        repeat (2) @(negedge ck);
    endtask
    // Mode-set: pins held across one clock rise, then idle for the spacing delay
    task automatic mode_set(input logic [2:0] b, input logic [12:0] a);
        @(negedge ck);
        {cs_n, ras_n, cas_n, we_n} = 4'h0;
        ba = b;
        addr = a;
        @(negedge ck);
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        addr = ~a; // Released bus shows something else
        repeat (4) @(negedge ck);
    endtask
    // Long calibration: select and write strobe low, never a mode-set
    task automatic zq_long();
        @(negedge ck);
        {cs_n, ras_n, cas_n, we_n} = 4'h6;
        addr = 13'h0400;
        @(negedge ck);
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        repeat (4) @(negedge ck);
    endtask
    // One strobe toggle, placed well inside the chosen clock half
    task automatic toggle(input int lane, input logic hi_half);
        if (hi_half) begin
            @(posedge ck);
        end else begin
            @(negedge ck);
        end
        #25;
        dqs[lane] = 1'b1;
        #30;
        dqs[lane] = 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== sim/ddr3_wl_core_bench.sv
// Self-checking bench for the leveling tracker against a pin-level model
`timescale 1ns/10ps
`default_nettype none
`include "ddr3_wl_defs.svh"
module ddr3_wl_core_bench;
    logic core_clk;
    logic rstn;
    logic ck, reset_n, cke, cs_n, ras_n, cas_n, we_n;
    logic [1:0] dqs;
    logic [2:0] ba;
    logic [12:0] addr;
    logic [15:0] dq_out, dq_oe;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_val;
    logic reg_wr, reg_rd;
    int n_mismatch, samples_checked, m_wlo, lane;
    // Reference state of the device
    logic m_level, m_qoff, m_dll, hi;
    logic [1:0] m_prime;

    ddr3_ctrl_model ctrl (.ck(ck), .dqs(dqs), .reset_n(reset_n), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));
    ddr3_wl_core #(.DQ_W(16)) dut (.core_clk(core_clk), .rstn(rstn), .ck(ck), .dqs(dqs),
        .reset_n(reset_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .ba(ba), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));

    // ==========================================================
    // Clock, watchdog and helpers
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Cuts a hang short
    initial begin
        #300us;
        n_mismatch++;
        end_sim();
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask
    task automatic check_status(input logic drv);
        reg_read(`OFF_STATUS);
        check(rd_val, {26'h0, m_prime, drv, m_dll, m_qoff, m_level});
    endtask
    // Enables all equal; prime bits carry the last sample, the rest low
    task automatic check_pins(input logic drv);
        check({16'h0, dq_oe}, drv ? 32'hffff : 32'h0);
        if (drv) begin
            check({16'h0, dq_out}, {23'h0, m_prime[1], 7'h0, m_prime[0]});
        end
    endtask
    task automatic strobe(input int ln, input logic h, input logic taken);
        ctrl.toggle(ln, h);
        if (taken) begin
            m_prime[ln] = h;
        end
        repeat (m_wlo + 8) @(posedge core_clk);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        rstn = 1'b0;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        {m_level, m_qoff, m_dll, m_prime} = 5'h0;
        n_mismatch = 0;
        samples_checked = 0;
        void'($urandom(74));
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        // Registers: reset values, read-only places, unmapped address
        reg_read(`OFF_CTRL);
        check(rd_val, 32'(`WLO_CYC));
        // Read data stand one cycle only
        @(posedge core_clk);
        #1;
        check(reg_rdata, 32'h0);
        reg_read(8'h0c);
        check(rd_val, 32'h0);
        m_wlo = $urandom % 4;
        reg_write(`OFF_CTRL, {28'($urandom), 4'(m_wlo)});
        reg_write(`OFF_STATUS, 32'hffff_ffff);
        reg_write(`OFF_DLLCNT, 32'hffff_ffff);
        reg_read(`OFF_CTRL);
        check(rd_val, 32'(m_wlo));
        reg_read(`OFF_DLLCNT);
        check(rd_val, 32'h0);
        check_status(1'b0);
        $display("test registers done");
        // Commands with clock enable low are ignored
        ctrl.set_pins(1'b1, 1'b0);
        ctrl.mode_set(`BA_MR1, 13'h0080);
        check_status(1'b0);
        ctrl.set_pins(1'b1, 1'b1);
        ctrl.mode_set(3'h2, 13'h0);
        ctrl.mode_set(3'h3, 13'h0);
        ctrl.mode_set(`BA_MR1, 13'h0);
        ctrl.mode_set(`BA_MR0, 13'h0100);
        ctrl.zq_long();
        repeat (490) @(posedge ck);
        check_status(1'b0);
        reg_read(`OFF_DLLCNT);
        check({31'h0, rd_val > 32'd490 && rd_val < 32'd510}, 32'h1);
        repeat (20) @(posedge ck);
        m_dll = 1'b1;
        check_status(1'b0);
        $display("test init done");
        // Leveling entry: data pins driven
        ctrl.mode_set(`BA_MR1, 13'h0080);
        m_level = 1'b1;
        check_pins(1'b1);
        check_status(1'b1);
        for (int i = 0; i < 10; i++) begin
            lane = $urandom % 2;
            hi = 1'($urandom % 2);
            strobe(lane, hi, 1'b1);
            check_pins(1'b1);
            check_status(1'b1);
        end
        $display("test feedback done");
        // Outputs off: strobes ignored, nothing driven
        ctrl.mode_set(`BA_MR1, 13'h1080);
        m_qoff = 1'b1;
        // Prime levels drop while this rank drives nothing
        m_prime = 2'h0;
        strobe(0, ~m_prime[0], 1'b0);
        check_pins(1'b0);
        check_status(1'b0);
        ctrl.mode_set(`BA_MR1, 13'h0080);
        m_qoff = 1'b0;
        strobe(1, 1'b1, 1'b1);
        check_pins(1'b1);
        $display("test outputs off done");
        // Exit: pins stay driven for the mode-set delay, then release
        ctrl.mode_set(`BA_MR1, 13'h0);
        m_level = 1'b0;
        repeat (6) @(posedge ck);
        check_pins(1'b1);
        check_status(1'b1);
        repeat (3) @(posedge ck);
        // Hold over: prime levels cleared with the drive
        m_prime = 2'h0;
        check_pins(1'b0);
        check_status(1'b0);
        $display("test exit done");
        // Voltage change: idle clocks, then DLL relock and long calibration
        repeat (8) @(posedge ck);
        ctrl.mode_set(`BA_MR0, 13'h0100);
        m_dll = 1'b0;
        check_status(1'b0);
        ctrl.zq_long();
        repeat (512) @(posedge ck);
        m_dll = 1'b1;
        check_status(1'b0);
        $display("test voltage change done");
        // Memory reset in mid-leveling clears the modes and the lock
        ctrl.mode_set(`BA_MR1, 13'h0080);
        m_level = 1'b1;
        check_status(1'b1);
        ctrl.set_pins(1'b0, 1'b0);
        {m_level, m_dll} = 2'h0;
        check_pins(1'b0);
        check_status(1'b0);
        $display("test memory reset done");
        end_sim();
    end
endmodule
`default_nettype wire
